/* src/etffc_filter_cells.sv */
/*
  Eight cascaded multiply-accumulate filter taps with shift-and-add
  output stage. Assumes all inputs come from logic on core_clk_i.
*/
`include "etffc_defines.svh"
`default_nettype none

// Contract
// - Eight taps: multiplier, three stages, accumulator
// - Output stage adds tap to buffer shifted
// - Sample and coefficient formats chosen independently
// - Coefficients enter tap zero, leave last tap
// - No decimation: coefficient out next cycle
// - Decimation adds one to three cycles
// - Coefficient enable registered, loads second edge
// - Coefficient enable high holds coefficient stages
// - Sample enable registered, loads second edge
// - Sample enable high loads zero samples
// - Extended product passes two pipeline stages
// - Sum written to accumulator and holding register
// - Accumulator updates every cycle unless cleared
// - Both clears low clear all tap registers and the buffer
// - Clear inputs registered, act second cycle
// - Selective clear alone clears addressed accumulator
// - Decimation select registered, picks stage count
// - Global alone clears registers; none when high
// - High format means signed, nine-bit internal
// - Drive enable low drives coefficient outputs

module etffc_filter_cells #(
  parameter int TAPS = `ETFFC_TAPS
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [`ETFFC_IN_W-1:0]    sample_in_bus_i,
  input  wire logic                      sample_load_n_i,
  input  wire logic                      sample_format_sel_i,
  input  wire logic [`ETFFC_IN_W-1:0]    coef_in_bus_i,
  input  wire logic                      coef_load_n_i,
  input  wire logic                      coef_format_sel_i,
  input  wire logic                      coef_out_drive_n_i,
  input  wire logic [`ETFFC_DCM_W-1:0]   decim_select_i,
  input  wire logic [`ETFFC_SEL_W-1:0]   tap_select_i,
  input  wire logic                      global_clear_n_i,
  input  wire logic                      select_clear_n_i,
  input  wire logic                      shift_add_sel_i,
  output logic      [`ETFFC_ACC_W-1:0]   result_bus_o,
  output logic      [`ETFFC_IN_W-1:0]    coef_out_bus_o,
  output logic                           coef_format_out_o,
  output logic                           coef_out_oe_n_o
);
  localparam int AW = `ETFFC_ACC_W;
  localparam int SH = `ETFFC_SHIFT;
  localparam int IW = `ETFFC_IN_W;
  localparam int SW = `ETFFC_SEL_W;

  localparam etffc_pkg::etffc_ctrl_s CTRL_RST = '{
    global_clear_n: `ETFFC_EN_RST,
    select_clear_n: `ETFFC_EN_RST,
    coef_load_n:    `ETFFC_EN_RST,
    sample_load_n:  `ETFFC_EN_RST,
    shift_add_sel:  1'b0,
    tap_select:     `ETFFC_SEL_RST
  };

  // Top bit is the sign for two's complement, zero for unsigned
  function automatic etffc_pkg::etffc_ext_t extend_word(
    input logic [IW-1:0] word,
    input logic          twos);
    extend_word = {twos & word[IW-1], word};
  endfunction : extend_word

  // ==========================================================
  // Input latching
  // ==========================================================
  etffc_pkg::etffc_ctrl_s ctrl_in;
  etffc_pkg::etffc_ctrl_s ctrl_q;
  logic [`ETFFC_DCM_W-1:0] decim_q;

  assign ctrl_in.global_clear_n = global_clear_n_i;
  assign ctrl_in.select_clear_n = select_clear_n_i;
  assign ctrl_in.coef_load_n    = coef_load_n_i;
  assign ctrl_in.sample_load_n  = sample_load_n_i;
  assign ctrl_in.shift_add_sel  = shift_add_sel_i;
  assign ctrl_in.tap_select     = tap_select_i;

  // One cycle of delay on every enable, clear and decimation select
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q  <= CTRL_RST;
      decim_q <= `ETFFC_DCM_RST;
    end else begin
      ctrl_q  <= ctrl_in;
      decim_q <= decim_select_i;
    end
  end

  // ==========================================================
  // Clear decode
  // ==========================================================
  wire logic clr_regs = !ctrl_q.global_clear_n;
  wire logic clr_one  = !ctrl_q.select_clear_n;
  wire logic coef_shift = !ctrl_q.coef_load_n;

  logic [TAPS-1:0] clr_acc;

  // ==========================================================
  // Sample and coefficient words
  // ==========================================================
  wire etffc_pkg::etffc_ext_t sample_ext =
      extend_word(sample_in_bus_i, sample_format_sel_i);
  wire etffc_pkg::etffc_ext_t sample_word =
      ctrl_q.sample_load_n ? '0 : sample_ext;
  wire etffc_pkg::etffc_ext_t coef_word =
      extend_word(coef_in_bus_i, coef_format_sel_i);
  wire etffc_pkg::etffc_decim_e next_decim =
      etffc_pkg::etffc_decim_e'(decim_q);

  // ==========================================================
  // Tap array
  // ==========================================================
  etffc_pkg::etffc_ext_t tap_coef [TAPS];
  etffc_pkg::etffc_acc_t tap_acc  [TAPS];

  for (genvar i = 0; i < TAPS; i++) begin : g_tap
    etffc_pkg::etffc_ext_t chain_in;

    if (i == 0) begin : g_head
      assign chain_in = coef_word;
    end else begin : g_link
      assign chain_in = tap_coef[i-1];
    end

    // Global clear widens the selective clear to every tap
    assign clr_acc[i] = clr_one &
        (clr_regs | (ctrl_q.tap_select == SW'(i)));

    etffc_tap_cell u_cell (
      .core_clk_i   (core_clk_i),
      .rst_i        (rst_i),
      .coef_shift_i (coef_shift),
      .clr_regs_i   (clr_regs),
      .clr_acc_i    (clr_acc[i]),
      .next_decim_i (next_decim),
      .coef_i       (chain_in),
      .sample_i     (sample_word),
      .coef_o       (tap_coef[i]),
      .acc_o        (tap_acc[i])
    );
  end

  // ==========================================================
  // Shift-and-add output stage
  // ==========================================================
  etffc_pkg::etffc_acc_t out_buf;
  logic                  shift_add_prev;
  logic [SW-1:0]         tap_select_prev;

  wire etffc_pkg::etffc_acc_t sel_acc = tap_acc[ctrl_q.tap_select];
  wire etffc_pkg::etffc_acc_t buf_shift = ctrl_q.shift_add_sel ?
      {{SH{out_buf[AW-1]}}, out_buf[AW-1:SH]} : '0;
  wire etffc_pkg::etffc_acc_t next_buf = sel_acc + buf_shift;
  wire logic acc_path = !ctrl_q.shift_add_sel && !shift_add_prev;
  // Holding the same address freezes the result for slow readers
  wire logic new_sel = ctrl_q.tap_select != tap_select_prev;
  wire etffc_pkg::etffc_acc_t next_result = acc_path ?
      (new_sel ? sel_acc : result_bus_o) : out_buf;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_buf         <= '0;
      shift_add_prev  <= 1'b0;
      tap_select_prev <= `ETFFC_SEL_RST;
    end else begin
      out_buf         <= clr_regs ? '0 : next_buf;
      shift_add_prev  <= ctrl_q.shift_add_sel;
      tap_select_prev <= ctrl_q.tap_select;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_bus_o <= '0;
    end else begin
      result_bus_o <= next_result;
    end
  end

  // ==========================================================
  // Coefficient output pins
  // ==========================================================
  // Last tap output is already a flop; only the low byte leaves
  assign coef_out_bus_o = tap_coef[TAPS-1][IW-1:0];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      coef_format_out_o <= 1'b0;
      coef_out_oe_n_o   <= `ETFFC_EN_RST;
    end else begin
      coef_format_out_o <= coef_format_sel_i;
      coef_out_oe_n_o   <= coef_out_drive_n_i;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_coef_req;
    (!coef_load_n_i && global_clear_n_i) ##1 1'b1;
  endsequence
  property p_coef_load;
    s_coef_req |=> g_tap[0].u_cell.coef_reg_value == $past(coef_word);
  endproperty
  a_coef_load: assert property (p_coef_load)
    else $error("coefficient not loaded on second edge");

  property p_coef_direct;
    (coef_shift && !clr_regs &&
     decim_q == `ETFFC_DCM_W'(etffc_pkg::DECIM_NONE))
      |=> tap_coef[0] == $past(coef_word);
  endproperty
  a_coef_direct: assert property (p_coef_direct)
    else $error("undecimated coefficient not out next cycle");

  sequence s_sample_req;
    (!sample_load_n_i && global_clear_n_i) ##1 1'b1;
  endsequence
  property p_sample_load;
    s_sample_req |=>
      g_tap[TAPS-1].u_cell.sample_reg_value == $past(sample_ext);
  endproperty
  a_sample_load: assert property (p_sample_load)
    else $error("sample not loaded on second edge");

  property p_sample_zero;
    sample_load_n_i |-> ##2 g_tap[0].u_cell.sample_reg_value == '0;
  endproperty
  a_sample_zero: assert property (p_sample_zero)
    else $error("idle sample register not zero");

  property p_clear_all;
    (!global_clear_n_i && !select_clear_n_i) |-> ##2
      (tap_acc[0] == '0 && tap_acc[TAPS-1] == '0 && out_buf == '0);
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("full clear not applied on second cycle");

  property p_clear_one;
    (ctrl_q.global_clear_n && !ctrl_q.select_clear_n)
      |=> tap_acc[$past(ctrl_q.tap_select)] == '0;
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("addressed accumulator not cleared");

  property p_clear_regs;
    (!ctrl_q.global_clear_n && ctrl_q.select_clear_n) |=>
      (out_buf == '0 && tap_coef[0] == '0 &&
       tap_acc[0] == $past(g_tap[0].u_cell.sum));
  endproperty
  a_clear_regs: assert property (p_clear_regs)
    else $error("register clear wrong or accumulator lost");

  property p_shift_add;
    (ctrl_q.shift_add_sel && !clr_regs) |=>
      out_buf == $past(sel_acc) +
        {{SH{$past(out_buf[AW-1])}}, $past(out_buf[AW-1:SH])};
  endproperty
  a_shift_add: assert property (p_shift_add)
    else $error("shift-and-add result wrong");

  property p_drive;
    coef_out_drive_n_i |=> coef_out_oe_n_o;
  endproperty
  a_drive: assert property (p_drive)
    else $error("coefficient bus driven while disabled");

  sequence s_coef_idle;
    (!coef_shift && !clr_regs) ##1
      (!coef_shift && !clr_regs && $stable(decim_q));
  endsequence
  property p_coef_still;
    s_coef_idle |=> $stable(tap_coef[TAPS-1]);
  endproperty
  a_coef_still: assert property (p_coef_still)
    else $error("held coefficient output moved");

  property p_chain;
    (coef_shift && !clr_regs) |=>
      g_tap[1].u_cell.coef_reg_value == $past(tap_coef[0]);
  endproperty
  a_chain: assert property (p_chain)
    else $error("coefficient did not move to next tap");

  property p_sample_format;
    (!ctrl_q.sample_load_n && !clr_regs) |=>
      g_tap[0].u_cell.sample_reg_value[IW] ==
        $past(sample_format_sel_i & sample_in_bus_i[IW-1]);
  endproperty
  a_sample_format: assert property (p_sample_format)
    else $error("sample extension bit wrong");

  property p_clear_coef;
    (!global_clear_n_i && !select_clear_n_i) |-> ##2
      (tap_coef[TAPS-1] == '0 &&
       g_tap[TAPS-1].u_cell.sample_reg_value == '0);
  endproperty
  a_clear_coef: assert property (p_clear_coef)
    else $error("full clear left a register set");

  property p_clear_spare;
    (ctrl_q.global_clear_n && !ctrl_q.select_clear_n &&
     ctrl_q.tap_select != '0) |=>
      tap_acc[0] == $past(g_tap[0].u_cell.sum);
  endproperty
  a_clear_spare: assert property (p_clear_spare)
    else $error("unaddressed accumulator cleared");

  property p_result_hold;
    (!ctrl_q.shift_add_sel && !shift_add_prev &&
     ctrl_q.tap_select == tap_select_prev) |=> $stable(result_bus_o);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed for a repeated address");

  property p_result_pick;
    (!ctrl_q.shift_add_sel && !shift_add_prev &&
     ctrl_q.tap_select != tap_select_prev) |=>
      result_bus_o == $past(tap_acc[ctrl_q.tap_select]);
  endproperty
  a_result_pick: assert property (p_result_pick)
    else $error("result missed newly addressed accumulator");

  property p_result_buf;
    (ctrl_q.shift_add_sel || shift_add_prev) |=>
      result_bus_o == $past(out_buf);
  endproperty
  a_result_buf: assert property (p_result_buf)
    else $error("result not taken from output buffer");
endmodule : etffc_filter_cells

`default_nettype wire

/* src/etffc_defines.svh */
/*
  Widths and reset values of the eight tap filter cells.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef ETFFC_DEFINES_SVH
`define ETFFC_DEFINES_SVH

`define ETFFC_TAPS     8
`define ETFFC_IN_W     8
`define ETFFC_EXT_W    9
`define ETFFC_PROD_W   18
`define ETFFC_ACC_W    26
`define ETFFC_SHIFT    8
`define ETFFC_SEL_W    3
`define ETFFC_DCM_W    2
`define ETFFC_EN_RST   1'b1
`define ETFFC_SEL_RST  3'h0
`define ETFFC_DCM_RST  2'h0

`endif

/* src/etffc_pkg.sv */
/*
  Types shared by the filter cell array and its taps.
  Assumes etffc_defines.svh is on the include path.
*/
`include "etffc_defines.svh"
`default_nettype none

package etffc_pkg;
  typedef logic [`ETFFC_EXT_W-1:0] etffc_ext_t;
  typedef logic [`ETFFC_ACC_W-1:0] etffc_acc_t;

  typedef enum logic [`ETFFC_DCM_W-1:0] {
    DECIM_NONE,
    DECIM_HALF,
    DECIM_THIRD,
    DECIM_FOURTH
  } etffc_decim_e;

  typedef struct packed {
    logic                    global_clear_n;
    logic                    select_clear_n;
    logic                    coef_load_n;
    logic                    sample_load_n;
    logic                    shift_add_sel;
    logic [`ETFFC_SEL_W-1:0] tap_select;
  } etffc_ctrl_s;
endpackage : etffc_pkg

`default_nettype wire

/* src/etffc_tap_cell.sv */
/*
  One filter tap: coefficient and decimation stages, sample register,
  two-stage product pipeline and accumulator with holding register.
  Assumes the array above it supplies already registered enables.
*/
`include "etffc_defines.svh"
`default_nettype none

module etffc_tap_cell #(
  parameter int EW = `ETFFC_EXT_W,
  parameter int PW = `ETFFC_PROD_W,
  parameter int AW = `ETFFC_ACC_W
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   coef_shift_i,
  input  wire logic                   clr_regs_i,
  input  wire logic                   clr_acc_i,
  input  wire etffc_pkg::etffc_decim_e next_decim_i,
  input  wire logic [EW-1:0]          coef_i,
  input  wire logic [EW-1:0]          sample_i,
  output logic      [EW-1:0]          coef_o,
  output logic      [AW-1:0]          acc_o
);
  logic        [EW-1:0] coef_reg_value;
  logic        [EW-1:0] decim_stage_one;
  logic        [EW-1:0] decim_stage_two;
  logic        [EW-1:0] decim_stage_three;
  logic        [EW-1:0] sample_reg_value;
  logic signed [PW-1:0] product_pipe_first;
  logic signed [PW-1:0] product_pipe_second;
  logic        [AW-1:0] hold_reg;

  function automatic logic [EW-1:0] pick_stage(
    input etffc_pkg::etffc_decim_e sel,
    input logic [EW-1:0] s0, s1, s2, s3);
    case (sel)
      etffc_pkg::DECIM_NONE:  pick_stage = s0;
      etffc_pkg::DECIM_HALF:  pick_stage = s1;
      etffc_pkg::DECIM_THIRD: pick_stage = s2;
      default:                pick_stage = s3;
    endcase
  endfunction : pick_stage

  // ==========================================================
  // Coefficient path
  // ==========================================================
  wire logic [EW-1:0] next_coef = clr_regs_i ? '0 :
      (coef_shift_i ? coef_i : coef_reg_value);
  wire logic [EW-1:0] next_one = clr_regs_i ? '0 :
      (coef_shift_i ? coef_reg_value : decim_stage_one);
  wire logic [EW-1:0] next_two = clr_regs_i ? '0 :
      (coef_shift_i ? decim_stage_one : decim_stage_two);
  wire logic [EW-1:0] next_three = clr_regs_i ? '0 :
      (coef_shift_i ? decim_stage_two : decim_stage_three);
  // Output flop mirrors the chosen stage, so no extra latency
  wire logic [EW-1:0] next_out = pick_stage(next_decim_i, next_coef,
      next_one, next_two, next_three);

  // ==========================================================
  // Multiply and accumulate
  // ==========================================================
  wire logic signed [PW-1:0] product =
      $signed(coef_reg_value) * $signed(sample_reg_value);
  wire logic [AW-1:0] addend =
      {{(AW-PW){product_pipe_second[PW-1]}}, product_pipe_second};
  wire logic [AW-1:0] sum = acc_o + addend;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      coef_reg_value      <= '0;
      decim_stage_one     <= '0;
      decim_stage_two     <= '0;
      decim_stage_three   <= '0;
      coef_o              <= '0;
      sample_reg_value    <= '0;
      product_pipe_first  <= '0;
      product_pipe_second <= '0;
      acc_o               <= '0;
      hold_reg            <= '0;
    end else begin
      coef_reg_value      <= next_coef;
      decim_stage_one     <= next_one;
      decim_stage_two     <= next_two;
      decim_stage_three   <= next_three;
      coef_o              <= next_out;
      sample_reg_value    <= clr_regs_i ? '0 : sample_i;
      product_pipe_first  <= clr_regs_i ? '0 : product;
      product_pipe_second <= clr_regs_i ? '0 : product_pipe_first;
      acc_o               <= clr_acc_i ? '0 : sum;
      hold_reg            <= clr_regs_i ? '0 : sum;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_pipe_run;
    !clr_regs_i ##1 !clr_regs_i;
  endsequence
  property p_product_pipe;
    @(posedge core_clk_i) disable iff (rst_i)
    s_pipe_run |=> product_pipe_second == $past(product, 2);
  endproperty
  a_product_pipe: assert property (p_product_pipe)
    else $error("product pipeline depth wrong");

  sequence s_decim_four;
    (coef_shift_i && !clr_regs_i &&
     next_decim_i == etffc_pkg::DECIM_FOURTH) [*4];
  endsequence
  property p_decim_delay;
    @(posedge core_clk_i) disable iff (rst_i)
    s_decim_four |=> coef_o == $past(coef_i, 4);
  endproperty
  a_decim_delay: assert property (p_decim_delay)
    else $error("three stage decimation delay wrong");

  property p_coef_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    (!coef_shift_i && !clr_regs_i) |=>
      $stable(coef_reg_value) && $stable(decim_stage_three);
  endproperty
  a_coef_hold: assert property (p_coef_hold)
    else $error("coefficient changed while held");

  property p_acc_update;
    @(posedge core_clk_i) disable iff (rst_i)
    (!clr_acc_i && !clr_regs_i) |=>
      acc_o == $past(sum) && hold_reg == acc_o;
  endproperty
  a_acc_update: assert property (p_acc_update)
    else $error("accumulator and holding register differ");
endmodule : etffc_tap_cell

`default_nettype wire

/* verif/etffc_src_model.sv */
/*
  Upstream source of samples and coefficients for the filter cells.
  Assumes the bench calls one of its tasks at a time, in one process.
*/
`default_nettype none

module etffc_src_model (
  input  wire logic       core_clk_i,
  output logic      [7:0] sample_in_bus_o,
  output logic            sample_load_n_o,
  output logic      [7:0] coef_in_bus_o,
  output logic            coef_load_n_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Idle levels
  initial begin
    sample_in_bus_o = 8'h00;
    sample_load_n_o = 1'b1;
    coef_in_bus_o   = 8'h00;
    coef_load_n_o   = 1'b1;
  end

  // ==========================================================
  // Streams; released lines show the inverse word, never a stale copy
  task send_coefs(input int n, input logic [7:0] base,
                  input logic [7:0] step);
    logic [7:0] w;
    w = base;
    @(posedge core_clk_i);
    coef_load_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      w = base + 8'(i) * step;
      coef_in_bus_o <= w;
      if (i == n - 1) begin
        coef_load_n_o <= 1'b1;
      end
    end
    @(posedge core_clk_i);
    coef_in_bus_o <= ~w;
  endtask : send_coefs

  task send_samples(input logic [7:0] x1, input logic [7:0] x2);
    @(posedge core_clk_i);
    sample_load_n_o <= 1'b0;
    @(posedge core_clk_i);
    sample_in_bus_o <= x1;
    @(posedge core_clk_i);
    sample_in_bus_o <= x2;
    sample_load_n_o <= 1'b1;
    @(posedge core_clk_i);
    sample_in_bus_o <= ~x2;
  endtask : send_samples
endmodule : etffc_src_model

`default_nettype wire

/* verif/testbench.sv */
/*
  Self-checking bench for the eight tap filter cells.
  Assumes the source model drives the sample and coefficient streams.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk;
  logic        rst;
  logic [7:0]  sample_in_bus;
  logic        sample_load_n;
  logic        sample_format_sel;
  logic [7:0]  coef_in_bus;
  logic        coef_load_n;
  logic        coef_format_sel;
  logic        coef_out_drive_n;
  logic [1:0]  decim_select;
  logic [2:0]  tap_select;
  logic        global_clear_n;
  logic        select_clear_n;
  logic        shift_add_sel;
  logic [25:0] result_bus;
  logic [7:0]  coef_out_bus;
  logic        coef_format_out;
  logic        coef_out_oe_n;
  logic [25:0] exp_acc [8];
  logic [25:0] b;
  int          errors;
  int          n_checks;

  etffc_filter_cells u_dut (
    .core_clk_i(core_clk), .rst_i(rst),
    .sample_in_bus_i(sample_in_bus), .sample_load_n_i(sample_load_n),
    .sample_format_sel_i(sample_format_sel),
    .coef_in_bus_i(coef_in_bus), .coef_load_n_i(coef_load_n),
    .coef_format_sel_i(coef_format_sel),
    .coef_out_drive_n_i(coef_out_drive_n),
    .decim_select_i(decim_select), .tap_select_i(tap_select),
    .global_clear_n_i(global_clear_n), .select_clear_n_i(select_clear_n),
    .shift_add_sel_i(shift_add_sel), .result_bus_o(result_bus),
    .coef_out_bus_o(coef_out_bus), .coef_format_out_o(coef_format_out),
    .coef_out_oe_n_o(coef_out_oe_n)
  );

  etffc_src_model u_src (
    .core_clk_i(core_clk), .sample_in_bus_o(sample_in_bus),
    .sample_load_n_o(sample_load_n), .coef_in_bus_o(coef_in_bus),
    .coef_load_n_o(coef_load_n)
  );

  // ==========================================================
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    $display("unexpected watchdog: expected finish, seen timeout");
    final_report();
  end

  // ==========================================================
  // Helpers
  function automatic logic [25:0] prod(input logic [7:0] c,
      input logic cf, input logic [7:0] x, input logic xf);
    logic signed [8:0]  ce;
    logic signed [8:0]  xe;
    logic signed [17:0] p;
    ce = {cf & c[7], c};
    xe = {xf & x[7], x};
    p = ce * xe;
    return {{8{p[17]}}, p};
  endfunction : prod

  task automatic check(input string what, input logic [25:0] exp,
                       input logic [25:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task final_report;
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // One cycle pulse; the clear lands two edges later
  task clear(input logic g, input logic s, input logic [2:0] t);
    @(posedge core_clk);
    global_clear_n <= g;
    select_clear_n <= s;
    tap_select     <= t;
    @(posedge core_clk);
    global_clear_n <= 1'b1;
    select_clear_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : clear

  // Address changes every read, else the result would hold
  task check_taps(input string what);
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      tap_select <= 3'(k);
      repeat (3) @(posedge core_clk);
      #1;
      check(what, exp_acc[k], result_bus);
    end
  endtask : check_taps

  // ==========================================================
  // Tests
  initial begin
    rst = 1'b1;
    sample_format_sel = 1'b0;
    coef_format_sel = 1'b0;
    coef_out_drive_n = 1'b1;
    decim_select = 2'h0;
    tap_select = 3'h0;
    global_clear_n = 1'b1;
    select_clear_n = 1'b1;
    shift_add_sel = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check("reset result", 26'h0, result_bus);
    check("reset oe_n", 26'h1, 26'(coef_out_oe_n));
    @(posedge core_clk);
    coef_out_drive_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("oe_n driven", 26'h0, 26'(coef_out_oe_n));
    $display("test reset done");

    for (int d = 0; d < 4; d++) begin
      @(posedge core_clk);
      decim_select <= 2'(d);
      clear(1'b0, 1'b0, 3'h3);
      u_src.send_coefs(8 * (d + 1) + 3, 8'h35, 8'h1B);
      #1;
      check("coef out", 26'h86, 26'(coef_out_bus));
      repeat (4) @(posedge core_clk);
      #1;
      check("coef out held", 26'h86, 26'(coef_out_bus));
    end
    $display("test decimation done");

    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk);
      coef_format_sel <= p[1];
      sample_format_sel <= p[0];
      decim_select <= 2'h0;
      clear(1'b0, 1'b0, 3'h3);
      u_src.send_coefs(8, 8'h81, 8'h2D);
      u_src.send_samples(8'hF3, 8'h47);
      repeat (8) @(posedge core_clk);
      for (int k = 0; k < 8; k++) begin
        exp_acc[k] = prod(8'h81 + 8'(7 - k) * 8'h2D, p[1], 8'hF3, p[0])
                   + prod(8'h81 + 8'(7 - k) * 8'h2D, p[1], 8'h47, p[0]);
      end
      check("coef format out", 26'(p[1]), 26'(coef_format_out));
      check_taps("tap accumulator");
      $display("test formats %0d done", p);
    end

    @(posedge core_clk);
    tap_select <= 3'h7;
    shift_add_sel <= 1'b0;
    repeat (2) @(posedge core_clk);
    b = exp_acc[7];
    for (int k = 6; k >= 0; k--) begin
      @(posedge core_clk);
      tap_select <= 3'(k);
      shift_add_sel <= 1'b1;
      b = exp_acc[k] + {{8{b[25]}}, b[25:8]};
    end
    @(posedge core_clk);
    shift_add_sel <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check("shift add result", b, result_bus);
    $display("test shift add done");

    clear(1'b1, 1'b0, 3'h3);
    exp_acc[3] = 26'h0;
    check_taps("after select clear");
    clear(1'b0, 1'b1, 3'h5);
    #1;
    check("coef out cleared", 26'h0, 26'(coef_out_bus));
    check_taps("after global clear");
    clear(1'b0, 1'b0, 3'h3);
    for (int k = 0; k < 8; k++) begin
      exp_acc[k] = 26'h0;
    end
    check_taps("after full clear");
    @(posedge core_clk);
    coef_out_drive_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("oe_n released", 26'h1, 26'(coef_out_oe_n));
    $display("test clears done");
    final_report();
  end
endmodule : testbench

`default_nettype wire
